/* File: rtl/power_monitor_fault_zc_config.sv */
// Purpose: Configuration words and fault, voltage event and crossing logic
// Assumes: Serial host port decoded upstream into a word register port
// Notes:   Logic runs from the shadow copies; nv writes refresh them
`timescale 1ns/1ps
`include "pmon_defines.svh"
module power_monitor_fault_zc_config #(
  parameter int ADC_FAST_CYC = `ADC_FAST_NS / `CLK_PERIOD_NS,
  parameter int ADC_SLOW_CYC = `ADC_SLOW_NS / `CLK_PERIOD_NS,
  parameter int ZC_SHORT_CYC = (`ZC_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int ZC_LONG_CYC  = (`ZC_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int DEL_DEPTH    = 8
) (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  // Register port
  input  wire logic [5:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [31:0]        reg_rdata_o,
  // Sample path
  input  wire logic               samp_valid_i,
  input  wire logic signed [15:0] vsamp_i,
  input  wire logic signed [15:0] isamp_i,
  output logic signed [15:0]      vsamp_o,
  output logic signed [15:0]      isamp_o,
  output logic                    adc_tick_o,
  // Power and rms
  input  wire logic signed [16:0] pactive_i,
  output logic signed [16:0]      pactive_o,
  input  wire logic               vrms_valid_i,
  input  wire logic [14:0]        vrms_i,
  input  wire logic [15:0]        i_mag_i,
  // Sample count
  input  wire logic [8:0]         dyn_n_i,
  input  wire logic [8:0]         prog_n_i,
  output logic      [8:0]         n_used_o,
  // Pins
  input  wire logic [1:0]         pin0_sel_i,
  input  wire logic [1:0]         pin1_sel_i,
  output logic                    digital_out_zero_o,
  output logic                    digital_out_one_o,
  output logic                    overcurrent_flag_o
);

  // ***************************************************
  // Fault delay cycle counts
  // ***************************************************
  localparam int FLT2_CYC = (`FLT_DLY2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FLT3_CYC = (`FLT_DLY3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FLT4_CYC = (`FLT_DLY4_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FLT5_CYC = (`FLT_DLY5_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FLT6_CYC = (`FLT_DLY6_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FLT7_CYC = (`FLT_DLY7_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // ***************************************************
  // Configuration words
  // ***************************************************
  logic [31:0] fzc_nv_q;
  logic [31:0] vev_nv_q;
  logic [31:0] fzc_sh_q;
  logic [31:0] vev_sh_q;
  logic        wr_fzc_nv;
  logic        wr_vev_nv;
  logic        wr_fzc_sh;
  logic        wr_vev_sh;
  logic [31:0] rd_mux;

  assign wr_fzc_nv = reg_wr_i && (reg_addr_i == `REG_FZC_NV);
  assign wr_vev_nv = reg_wr_i && (reg_addr_i == `REG_VEV_NV);
  assign wr_fzc_sh = reg_wr_i && (reg_addr_i == `REG_FZC_SHADOW);
  assign wr_vev_sh = reg_wr_i && (reg_addr_i == `REG_VEV_SHADOW);

  assign rd_mux = (reg_addr_i == `REG_FZC_NV)     ? fzc_nv_q :
                  (reg_addr_i == `REG_VEV_NV)     ? vev_nv_q :
                  (reg_addr_i == `REG_FZC_SHADOW) ? fzc_sh_q :
                  (reg_addr_i == `REG_VEV_SHADOW) ? vev_sh_q : 32'h0000_0000;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fzc_nv_q    <= `FZC_RESET;
      vev_nv_q    <= `VEV_RESET;
      fzc_sh_q    <= `FZC_RESET;
      vev_sh_q    <= `VEV_RESET;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      if (wr_fzc_nv) fzc_nv_q <= reg_wdata_i;
      if (wr_vev_nv) vev_nv_q <= reg_wdata_i;
      if (wr_fzc_nv || wr_fzc_sh) fzc_sh_q <= reg_wdata_i;
      if (wr_vev_nv || wr_vev_sh) vev_sh_q <= reg_wdata_i;
      if (reg_rd_i) reg_rdata_o <= rd_mux;
    end
  end

  // ***************************************************
  // Field decode
  // ***************************************************
  logic signed [6:0] trim;
  logic              ichan_sel;
  logic [2:0]        del_code;
  logic [7:0]        fault_code;
  logic [2:0]        fltdly_code;
  logic              half_en;
  logic              square_en;
  logic [5:0]        cycs_code;
  logic              rate_slow;
  logic              bypass_en;
  logic [5:0]        ov_code;
  logic [5:0]        uv_code;
  logic              wide_sel;

  assign trim        = fzc_sh_q[`F_TRIM_MSB:`F_TRIM_LSB];
  assign ichan_sel   = fzc_sh_q[`F_ICHAN_BIT];
  assign del_code    = fzc_sh_q[`F_DEL_MSB:`F_DEL_LSB];
  assign fault_code  = fzc_sh_q[`F_FAULT_MSB:`F_FAULT_LSB];
  assign fltdly_code = fzc_sh_q[`F_FLTDLY_MSB:`F_FLTDLY_LSB];
  assign half_en     = fzc_sh_q[`F_HALF_BIT];
  assign square_en   = fzc_sh_q[`F_SQUARE_BIT];
  assign cycs_code   = vev_sh_q[`F_CYCS_MSB:`F_CYCS_LSB];
  assign rate_slow   = vev_sh_q[`F_RATE_BIT];
  assign bypass_en   = vev_sh_q[`F_BYPASS_BIT];
  assign ov_code     = vev_sh_q[`F_OVTHR_MSB:`F_OVTHR_LSB];
  assign uv_code     = vev_sh_q[`F_UVTHR_MSB:`F_UVTHR_LSB];
  assign wide_sel    = vev_sh_q[`F_WIDTH_BIT];

  // ***************************************************
  // Voltage ADC rate and active power trim
  // ***************************************************
  logic [12:0]        rate_cnt_q;
  logic [12:0]        rate_top;
  logic signed [16:0] trim_ext;
  logic signed [16:0] trim_scaled;

  assign rate_top    = rate_slow ? 13'(ADC_SLOW_CYC - 1) : 13'(ADC_FAST_CYC - 1);
  assign adc_tick_o  = (rate_cnt_q == 13'h0000);
  assign trim_ext    = 17'(trim);
  assign trim_scaled = (trim_ext <<< 2) + (trim_ext <<< 1);

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rate_cnt_q <= 13'h0000;
      pactive_o  <= 17'sh00000;
    end else begin
      rate_cnt_q <= (rate_cnt_q >= rate_top) ? 13'h0000 : rate_cnt_q + 13'h0001;
      pactive_o  <= pactive_i + trim_scaled;
    end
  end

  // ***************************************************
  // Phase delay line
  // ***************************************************
  logic signed [15:0] del_line_q [DEL_DEPTH];
  logic signed [15:0] del_in;
  logic signed [15:0] del_out;

  assign del_in  = ichan_sel ? isamp_i : vsamp_i;
  assign del_out = (del_code == 3'h0) ? del_in : del_line_q[del_code - 3'h1];

  genvar gi;
  generate
    for (gi = 0; gi < DEL_DEPTH; gi++) begin : g_del
      always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          del_line_q[gi] <= 16'sh0000;
        end else if (samp_valid_i) begin
          del_line_q[gi] <= (gi == 0) ? del_in : del_line_q[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vsamp_o <= 16'sh0000;
      isamp_o <= 16'sh0000;
    end else if (samp_valid_i) begin
      vsamp_o <= ichan_sel ? vsamp_i : del_out;
      isamp_o <= ichan_sel ? del_out : isamp_i;
    end
  end

  // ***************************************************
  // Overcurrent detection
  // ***************************************************
  logic [22:0] oc_prod;
  logic [15:0] oc_level;
  logic        oc_over;
  logic [10:0] flt_target;
  logic        oc_hit;

  assign oc_prod  = 23'(fault_code) * `OC_SPAN;
  assign oc_level = `OC_BASE + 16'(oc_prod / `OC_CODE_MAX);
  assign oc_over  = (i_mag_i > oc_level);

  always_comb begin
    unique case (fltdly_code)
      3'h2:    flt_target = 11'(FLT2_CYC);
      3'h3:    flt_target = 11'(FLT3_CYC);
      3'h4:    flt_target = 11'(FLT4_CYC);
      3'h5:    flt_target = 11'(FLT5_CYC);
      3'h6:    flt_target = 11'(FLT6_CYC);
      3'h7:    flt_target = 11'(FLT7_CYC);
      default: flt_target = 11'h000;
    endcase
  end

  event_qualifier #(.W(11)) u_oc_qual (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .step_i   (1'b1),
    .cond_i   (oc_over),
    .target_i (flt_target),
    .hit_o    (oc_hit)
  );

  // ***************************************************
  // Over and undervoltage
  // ***************************************************
  logic [14:0] vrms_q;
  logic [14:0] vrms_now;
  logic [15:0] ov_thr;
  logic [15:0] uv_thr;
  logic        ov_cond;
  logic        uv_cond;
  logic        ov_hit;
  logic        uv_hit;
  logic [10:0] cyc_target;

  assign ov_thr     = 16'(ov_code) << `VTHR_SHIFT;
  assign uv_thr     = 16'(uv_code) << `VTHR_SHIFT;
  // Fresh result qualifies on its own strobe
  assign vrms_now   = vrms_valid_i ? vrms_i : vrms_q;
  assign ov_cond    = (16'(vrms_now) > ov_thr);
  assign uv_cond    = (16'(vrms_now) < uv_thr);
  assign cyc_target = 11'(cycs_code) + 11'h001;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vrms_q <= 15'h0000;
    end else if (vrms_valid_i) begin
      vrms_q <= vrms_i;
    end
  end

  event_qualifier #(.W(11)) u_ov_qual (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .step_i   (vrms_valid_i),
    .cond_i   (ov_cond),
    .target_i (cyc_target),
    .hit_o    (ov_hit)
  );

  event_qualifier #(.W(11)) u_uv_qual (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .step_i   (vrms_valid_i),
    .cond_i   (uv_cond),
    .target_i (cyc_target),
    .hit_o    (uv_hit)
  );

  // ***************************************************
  // Zero crossing
  // ***************************************************
  logic prev_neg_q;
  logic zc_event;
  logic zc_out;

  assign zc_event = samp_valid_i &&
                    ((prev_neg_q && !vsamp_i[15]) ||
                     (half_en && !prev_neg_q && vsamp_i[15]));

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_neg_q <= 1'b0;
    end else if (samp_valid_i) begin
      prev_neg_q <= vsamp_i[15];
    end
  end

  crossing_pulse #(
    .CW       (14),
    .SHORT_CYC(ZC_SHORT_CYC),
    .LONG_CYC (ZC_LONG_CYC)
  ) u_zc (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .event_i  (zc_event),
    .square_i (square_en),
    .wide_i   (wide_sel),
    .cross_o  (zc_out)
  );

  // ***************************************************
  // Output pins and sample count
  // ***************************************************
  pmon_pkg::pin0_sel_type d0_sel;
  pmon_pkg::pin1_sel_type d1_sel;
  logic                   d0_d;
  logic                   d1_d;

  assign d0_sel = pmon_pkg::pin0_sel_type'(pin0_sel_i);
  assign d1_sel = pmon_pkg::pin1_sel_type'(pin1_sel_i);

  always_comb begin
    unique case (d0_sel)
      pmon_pkg::PIN0_CROSSING: d0_d = zc_out;
      pmon_pkg::PIN0_OVER:     d0_d = ov_hit;
      pmon_pkg::PIN0_UNDER:    d0_d = uv_hit;
      pmon_pkg::PIN0_OV_OR_UV: d0_d = ov_hit | uv_hit;
    endcase
  end

  always_comb begin
    unique case (d1_sel)
      pmon_pkg::PIN1_OVERCUR: d1_d = oc_hit;
      pmon_pkg::PIN1_UNDER:   d1_d = uv_hit;
      pmon_pkg::PIN1_OVER:    d1_d = ov_hit;
      pmon_pkg::PIN1_ANY:     d1_d = ov_hit | uv_hit | oc_hit;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      digital_out_zero_o <= 1'b0;
      digital_out_one_o  <= 1'b0;
      overcurrent_flag_o <= 1'b0;
      n_used_o           <= 9'h000;
    end else begin
      digital_out_zero_o <= d0_d;
      digital_out_one_o  <= d1_d;
      overcurrent_flag_o <= oc_hit;
      n_used_o           <= bypass_en ? prog_n_i : dyn_n_i;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  chk_power_trim: assert property (
    pactive_o == $past(pactive_i) + 17'(6 * $past(trim))
  ) else $error("Active power trim wrong");

  chk_delay_route: assert property (
    (samp_valid_i && !ichan_sel) |=> (isamp_o == $past(isamp_i))
  ) else $error("Undelayed current channel altered");

  chk_oc_immediate: assert property (
    (oc_over && fltdly_code <= 3'h1) |=> overcurrent_flag_o
  ) else $error("Overcurrent without delay not flagged");

  chk_oc_persist: assert property (
    (!oc_over && fltdly_code >= 3'h2) |=> !overcurrent_flag_o ##1 !overcurrent_flag_o
  ) else $error("Overcurrent flagged before delay");

  chk_ov_level: assert property (
    digital_out_zero_o && d0_sel == pmon_pkg::PIN0_OVER && $stable(d0_sel)
      |-> $past(ov_cond)
  ) else $error("Overvoltage flag without level");

  chk_uv_pin_one: assert property (
    (d1_sel == pmon_pkg::PIN1_UNDER) |=> (digital_out_one_o == $past(uv_hit))
  ) else $error("Pin one undervoltage route wrong");

  chk_uv_level: assert property (
    uv_hit |-> (16'(vrms_q) < uv_thr)
  ) else $error("Undervoltage flag above threshold");

  chk_pin_zero_or: assert property (
    (d0_sel == pmon_pkg::PIN0_OV_OR_UV) |=> (digital_out_zero_o == $past(ov_hit || uv_hit))
  ) else $error("Pin zero OR route wrong");

  chk_n_select: assert property (
    !bypass_en |=> (n_used_o == $past(dyn_n_i))
  ) else $error("Programmed count used without bypass");

  chk_tick_spacing: assert property (
    adc_tick_o |=> !adc_tick_o [*8]
  ) else $error("Rate ticks too close");

endmodule

/* File: rtl/pmon_defines.svh */
// Purpose: Offsets, field positions, reset values, scales and timing in ns
// Assumes: 50 MHz mclk_i
// Notes:   Included by the top design file of the block only
`ifndef PMON_DEFINES_SVH
`define PMON_DEFINES_SVH

// ***************************************************
// Register offsets and reset values
// ***************************************************
`define REG_FZC_NV        6'h0d
`define REG_VEV_NV        6'h0e
`define REG_FZC_SHADOW    6'h1d
`define REG_VEV_SHADOW    6'h1e
`define FZC_RESET         32'h0000_0000
`define VEV_RESET         32'h0000_0000

// ***************************************************
// Field positions
// ***************************************************
`define F_TRIM_MSB        6
`define F_TRIM_LSB        0
`define F_ICHAN_BIT       7
`define F_DEL_MSB         11
`define F_DEL_LSB         9
`define F_FAULT_MSB       20
`define F_FAULT_LSB       13
`define F_FLTDLY_MSB      23
`define F_FLTDLY_LSB      21
`define F_HALF_BIT        24
`define F_SQUARE_BIT      25
`define F_CYCS_MSB        5
`define F_CYCS_LSB        0
`define F_RATE_BIT        6
`define F_BYPASS_BIT      7
`define F_OVTHR_MSB       13
`define F_OVTHR_LSB       8
`define F_UVTHR_MSB       19
`define F_UVTHR_LSB       14
`define F_WIDTH_BIT       20

// ***************************************************
// Scales and timing
// ***************************************************
`define VTHR_SHIFT        9
`define OC_BASE           16'h2000
`define OC_SPAN           23'h005000
`define OC_CODE_MAX       23'h0000ff
`define CLK_PERIOD_NS     20
`define ADC_FAST_NS       31250
`define ADC_SLOW_NS       125000
`define FLT_DLY2_NS       4750
`define FLT_DLY3_NS       9250
`define FLT_DLY4_NS       13750
`define FLT_DLY5_NS       18500
`define FLT_DLY6_NS       23250
`define FLT_DLY7_NS       27750
`define ZC_SHORT_NS       32000
`define ZC_LONG_NS        256000

`endif

/* File: rtl/pmon_pkg.sv */
// Purpose: Shared types of the power monitor configuration block
// Assumes: Nothing
// Notes:   Constants live in pmon_defines.svh
package pmon_pkg;

  typedef enum logic [1:0] {
    PIN0_CROSSING = 2'b00,
    PIN0_OVER     = 2'b01,
    PIN0_UNDER    = 2'b10,
    PIN0_OV_OR_UV = 2'b11
  } pin0_sel_type;

  typedef enum logic [1:0] {
    PIN1_OVERCUR  = 2'b00,
    PIN1_UNDER    = 2'b01,
    PIN1_OVER     = 2'b10,
    PIN1_ANY      = 2'b11
  } pin1_sel_type;

endpackage

/* File: rtl/event_qualifier.sv */
// Purpose: Counts consecutive qualified steps and flags when target reached
// Assumes: cond_i and step_i on mclk_i
// Notes:   Count restarts whenever the condition drops
`timescale 1ns/1ps
module event_qualifier #(
  parameter int W = 11
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  // Qualification
  input  wire logic         step_i,
  input  wire logic         cond_i,
  input  wire logic [W-1:0] target_i,
  output logic              hit_o
);

  logic [W-1:0] cnt_q;
  logic         cnt_full;

  assign cnt_full = &cnt_q;
  assign hit_o    = cond_i && (cnt_q >= target_i);

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else if (!cond_i) begin
      cnt_q <= '0;
    end else if (step_i && !cnt_full) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  chk_hit_count: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    hit_o |-> cond_i && $past(cond_i) || (target_i == '0)
  ) else $error("Qualified flag without held condition");

endmodule

/* File: rtl/crossing_pulse.sv */
// Purpose: Shapes zero-crossing events into pulses or a toggling level
// Assumes: event_i is a one-cycle strobe
// Notes:   Width counts come from the top-level parameters
`timescale 1ns/1ps
module crossing_pulse #(
  parameter int CW        = 14,
  parameter int SHORT_CYC = 1600,
  parameter int LONG_CYC  = 12800
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Control
  input  wire logic event_i,
  input  wire logic square_i,
  input  wire logic wide_i,
  // Output
  output logic      cross_o
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] load_len;
  logic          out_q;

  assign load_len = wide_i ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
  assign cross_o  = out_q;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= 1'b0;
      cnt_q <= '0;
    end else if (event_i && square_i) begin
      out_q <= ~out_q;
      cnt_q <= '0;
    end else if (event_i) begin
      out_q <= 1'b1;
      cnt_q <= load_len;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end else if (!square_i) begin
      out_q <= 1'b0;
    end
  end

  chk_pulse_short: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (event_i && !square_i && !out_q) |=> out_q [*8]
  ) else $error("Crossing pulse ended too early");

  chk_square_toggle: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (event_i && square_i) |=> (out_q != $past(out_q))
  ) else $error("Square output did not toggle");

endmodule

/* File: bench/host_model.sv */
// Purpose: Host side of the register port and the pin select words
// Assumes: One strobe per word access
// Notes:   Write data is inverted once the strobe drops
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic        mclk_i,
  // Register port
  output logic      [5:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [31:0] rdata_i,
  // Pin selects
  output logic      [1:0]  pin0_sel_o,
  output logic      [1:0]  pin1_sel_o
);
  initial begin
    addr_o = 6'h00;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    pin0_sel_o = 2'h0;
    pin1_sel_o = 2'h0;
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    @(posedge mclk_i);
    #1 d = rdata_i;
  endtask
  task automatic sel(input logic [1:0] s0, input logic [1:0] s1);
    @(posedge mclk_i);
    pin0_sel_o <= s0;
    pin1_sel_o <= s1;
  endtask
endmodule

/* File: bench/testbench.sv */
// Purpose: Self-checking bench of the configuration and detection block
// Assumes: Shortened ADC and pulse counts
// Notes:   Host model owns the register port
`timescale 1ns/1ps
module testbench;
  // ***************************************************
  // Signals
  // ***************************************************
  localparam int FST = 20;
  localparam int SLW = 40;
  localparam int ZSH = 16;
  localparam int ZLG = 64;
  logic               mclk_i, sys_rst_i, samp_valid_i, vrms_valid_i;
  logic signed [15:0] vsamp_i, isamp_i;
  wire signed  [15:0] vsamp_o, isamp_o;
  logic signed [16:0] pactive_i;
  wire signed  [16:0] pactive_o;
  logic        [14:0] vrms_i;
  logic        [15:0] i_mag_i;
  logic        [8:0]  dyn_n_i, prog_n_i;
  wire         [8:0]  n_used_o;
  wire         [5:0]  addr;
  wire         [31:0] wdata, rdata;
  wire         [1:0]  s0, s1;
  wire                wr, rd, adc_tick_o, pin0, pin1, oc_pin;
  logic        [31:0] d, w, seed;
  logic signed [6:0]  t;
  logic        [7:0]  fl;
  logic        [2:0]  dl;
  int                 n, c, cyc, n_mismatch, total_checks;
  logic        [5:0]  adr [5] = '{6'h0d, 6'h0e, 6'h1d, 6'h1e, 6'h05};
  int                 zn [7] = '{0, ZSH, 0, ZLG, ZSH, 1, 0};
  localparam logic [6:0] ZW = 7'b1101100;
  localparam logic [6:0] ZH = 7'b1010000;
  localparam logic [6:0] ZQ = 7'b1100000;

  host_model host_model_i (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata), .pin0_sel_o(s0), .pin1_sel_o(s1));
  power_monitor_fault_zc_config #(.ADC_FAST_CYC(FST), .ADC_SLOW_CYC(SLW),
    .ZC_SHORT_CYC(ZSH), .ZC_LONG_CYC(ZLG)) power_monitor_fault_zc_config_i (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .samp_valid_i(samp_valid_i),
    .vsamp_i(vsamp_i), .isamp_i(isamp_i), .vsamp_o(vsamp_o), .isamp_o(isamp_o),
    .adc_tick_o(adc_tick_o), .pactive_i(pactive_i), .pactive_o(pactive_o),
    .vrms_valid_i(vrms_valid_i), .vrms_i(vrms_i), .i_mag_i(i_mag_i), .dyn_n_i(dyn_n_i),
    .prog_n_i(prog_n_i), .n_used_o(n_used_o), .pin0_sel_i(s0), .pin1_sel_i(s1),
    .digital_out_zero_o(pin0), .digital_out_one_o(pin1), .overcurrent_flag_o(oc_pin));

  // ***************************************************
  // Helpers
  // ***************************************************
  function automatic logic [31:0] fzc(logic [6:0] tr, logic ic, logic [2:0] de,
                                      logic [7:0] f, logic [2:0] fd, logic hf, logic sq);
    return {6'h00, sq, hf, fd, f, 1'b0, de, 1'b0, ic, tr};
  endfunction
  function automatic logic [31:0] vev(logic [5:0] cy, logic rt, logic by,
                                      logic [5:0] ov, logic [5:0] uv, logic wd);
    return {11'h000, wd, uv, ov, by, rt, cy};
  endfunction
  function automatic logic [15:0] oc_thr(logic [7:0] code);
    return 16'(8192 + (int'(code) * 20480) / 255);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic samp(input logic signed [15:0] v, input logic signed [15:0] i);
    @(posedge mclk_i);
    samp_valid_i <= 1'b1;
    vsamp_i <= v;
    isamp_i <= i;
    @(posedge mclk_i);
    samp_valid_i <= 1'b0;
  endtask
  task automatic vr(input logic [14:0] v, input int k);
    repeat (k) begin
      @(posedge mclk_i);
      vrms_valid_i <= 1'b1;
      vrms_i <= v;
      @(posedge mclk_i);
      vrms_valid_i <= 1'b0;
    end
    repeat (3) @(posedge mclk_i);
    #1;
  endtask
  task automatic oc(input logic [15:0] v, input int k, input logic e);
    @(posedge mclk_i);
    i_mag_i <= v;
    repeat (k) @(posedge mclk_i);
    #1 chk(oc_pin, e);
    chk(pin1, e);
  endtask
  task automatic tick(output int k);
    k = 0;
    do begin
      @(posedge mclk_i);
      #1 k++;
    end while (adc_tick_o !== 1'b1 && k < 100);
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ***************************************************
  // Clock, timeout and sequence
  // ***************************************************
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    seed = 32'heb2da093;
    {sys_rst_i, samp_valid_i, vrms_valid_i} = 3'b100;
    {vsamp_i, isamp_i, pactive_i, vrms_i} = '0;
    {i_mag_i, dyn_n_i, prog_n_i} = '0;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      host_model_i.rd(adr[k], d);
      chk(d, 32'h0);
    end
    w = $random(seed) & 32'h03ffeeff;
    host_model_i.wr(6'h0d, w);
    host_model_i.wr(6'h05, w);
    host_model_i.rd(6'h1d, d);
    chk(d, w);
    host_model_i.rd(6'h05, d);
    chk(d, 32'h0);
    host_model_i.wr(6'h1e, 32'h001fffff & ~w);
    host_model_i.rd(6'h0e, d);
    chk(d, 32'h0);
    host_model_i.rd(6'h1e, d);
    chk(d, 32'h001fffff & ~w);
    for (int k = 0; k < 3; k++) begin
      t = (k == 0) ? -7'sd64 : (k == 1) ? 7'sd63 : 7'($random(seed));
      host_model_i.wr(6'h1d, fzc(t, 1'b0, 3'd0, 8'h00, 3'd0, 1'b0, 1'b0));
      @(posedge mclk_i);
      pactive_i <= 17'($random(seed) % 60000);
      @(posedge mclk_i);
      #1 chk(32'(pactive_o), 32'(pactive_i + 17'(6 * t)));
    end
    for (int m = 0; m < 2; m++) begin
      dl = m ? 3'd7 : 3'd3;
      host_model_i.wr(6'h1d, fzc(7'h00, m[0], dl, 8'h00, 3'd0, 1'b0, 1'b0));
      for (int k = 0; k < 16; k++) begin
        samp(16'(k + 1), 16'(k + 1001));
        #1;
        if (k >= 8) begin
          chk(32'(m ? vsamp_o : isamp_o), 32'(m ? k + 1 : k + 1001));
          chk(32'(m ? isamp_o : vsamp_o), 32'(m ? k + 1001 - dl : k + 1 - dl));
        end
      end
    end
    for (int k = 0; k < 3; k++) begin
      fl = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      host_model_i.wr(6'h1d, fzc(7'h00, 1'b0, 3'd0, fl, 3'd0, 1'b0, 1'b0));
      oc(oc_thr(fl) + 16'd1, 3, 1'b1);
      oc(oc_thr(fl), 3, 1'b0);
    end
    host_model_i.wr(6'h1d, fzc(7'h00, 1'b0, 3'd0, 8'h00, 3'd2, 1'b0, 1'b0));
    oc(16'h3000, 200, 1'b0);
    oc(16'h0000, 2, 1'b0);
    oc(16'h3000, 234, 1'b0);
    oc(16'h3000, 8, 1'b1);
    oc(16'h0000, 3, 1'b0);
    host_model_i.sel(2'd1, 2'd1);
    host_model_i.wr(6'h1e, vev(6'd2, 1'b0, 1'b0, 6'd20, 6'd10, 1'b0));
    vr(15'd10241, 2);
    chk(pin0, 1'b0);
    vr(15'd10241, 1);
    chk(pin0, 1'b1);
    vr(15'd10240, 1);
    chk(pin0, 1'b0);
    vr(15'd5119, 3);
    chk(pin1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      host_model_i.sel(2'(k), 2'(k));
      repeat (3) @(posedge mclk_i);
      #1 chk(pin1, k[0]);
      if (k > 0) chk(pin0, k > 1);
    end
    host_model_i.sel(2'd0, 2'd0);
    for (int k = 0; k < 7; k++) begin
      host_model_i.wr(6'h1e, vev(6'd0, 1'b0, 1'b0, 6'd63, 6'd0, ZW[k]));
      host_model_i.wr(6'h1d, fzc(7'h00, 1'b0, 3'd0, 8'h00, 3'd0, ZH[k], ZQ[k]));
      samp(k[0] ? 16'sd5 : -16'sd5, 16'sd0);
      n = 0;
      for (int j = 0; j < 80; j++) begin
        #1 n += pin0;
        @(posedge mclk_i);
      end
      #1 chk(ZQ[k] ? 32'(pin0) : 32'(n), zn[k]);
    end
    for (int k = 0; k < 4; k++) begin
      host_model_i.wr(6'h1e, vev(6'd0, 1'b0, k[0], 6'd0, 6'd0, 1'b0));
      @(posedge mclk_i);
      dyn_n_i <= 9'($random(seed));
      prog_n_i <= (k == 3) ? 9'h1ff : 9'($random(seed));
      repeat (2) @(posedge mclk_i);
      #1 chk(n_used_o, k[0] ? prog_n_i : dyn_n_i);
    end
    for (int k = 0; k < 2; k++) begin
      host_model_i.wr(6'h1e, vev(6'd0, k[0], 1'b0, 6'd0, 6'd0, 1'b0));
      tick(c);
      tick(c);
      chk(c, k ? SLW : FST);
    end
    end_sim();
  end
endmodule
